// ---- rtl/mfio_pin_cell.sv ----
// Package of shared constants and the per-pin output driver cell of the I/O port block.
package mfio_pkg;
  localparam int          PORT_W         = 8;
  localparam int          NPORT          = 6;
  localparam int          ADDR_W         = 6;
  localparam logic [2:0]  PORT_A         = 3'h0;
  localparam logic [2:0]  PORT_B         = 3'h1;
  localparam logic [2:0]  PORT_C         = 3'h2;
  localparam logic [2:0]  PORT_D         = 3'h3;
  localparam logic [2:0]  PORT_E         = 3'h4;
  localparam logic [2:0]  PORT_G         = 3'h5;
  localparam logic [2:0]  PORT_MISC      = 3'h7;
  localparam logic [2:0]  REG_DATA_IN    = 3'h0;
  localparam logic [2:0]  REG_DATA_OUT   = 3'h1;
  localparam logic [2:0]  REG_DIRECTION  = 3'h2;
  localparam logic [2:0]  REG_DRIVE      = 3'h3;
  localparam logic [2:0]  REG_ENABLE_OUT = 3'h4;
  localparam logic [2:0]  REG_ISP_CTRL   = 3'h0;
  localparam int          ISP_EN_BIT     = 0;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  FULL_MASK      = 8'hff;
  localparam logic [7:0]  PORT_D_MASK    = 8'h0f;
  localparam int          ISP_TMS_BIT    = 0;
  localparam int          ISP_TCK_BIT    = 1;
  localparam int          ISP_TDI_BIT    = 2;
  localparam int          ISP_TDO_BIT    = 3;
  localparam int          PD_CLK_BIT     = 1;
  localparam int          PD_CSI_BIT     = 2;
  localparam int          PD_UBW_BIT     = 3;
  typedef enum logic [1:0] {
    ISC_PASS  = 2'b00,
    ISC_LATCH = 2'b01,
    ISC_REG   = 2'b10
  } mfio_isc_mode_t;
endpackage

`timescale 1ns/1ns
`default_nettype none
module mfio_pin_cell (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Sources and drive controls.
  input  wire logic dout_bit,
  input  wire logic dir,
  input  wire logic open_drain,
  input  wire logic alt_en,
  input  wire logic alt_bit,
  input  wire logic alt_oe,
  input  wire logic force_in,
  // Pin driver.
  output logic      pin_o,
  output logic      pin_oe
);
  logic src;
  logic next_pin_o;
  logic next_pin_oe;

  always_comb begin
    src         = alt_en ? alt_bit : dout_bit;
    next_pin_oe = (alt_oe | dir) & ~force_in & (~open_drain | ~src);
    next_pin_o  = src & ~open_drain;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_o  <= next_pin_o;
      pin_oe <= next_pin_oe;
    end
  end

  dir_drives_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      (dir && !force_in && !open_drain) |=> pin_oe)
    else $error("Direction bit set but driver off.");
  alt_priority_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      (alt_en && !open_drain) |=> pin_o == $past(alt_bit))
    else $error("Array output lost priority over data out.");
endmodule
`default_nettype wire

// ---- rtl/mfio_port_mux.sv ----
// Top level of the seven-port I/O multiplexer with its processor-visible port registers.
// Summary of operation
// - Enable status register shows driver activity.
// - Port F always carries data bits 7-0.
// - Port G data high byte in 16-bit.
// - Programming port only on port E.
// - Macrocell groups drive ports A and B.
// - Decoded selects drive port C only.
// - Ports A-C enter arrays via input cells.
// - Port D four pins, direct array inputs.
// - Port C fast slew; A,B,G open drain.
// - Port D pin one clocks arrays.
// - Port D pin two high deselects memories.
// - Deselect leaves arrays and signals running.
// - Port D pin three upper-byte write strobe.
// - Port E I/O, open drain, programming.
// - Direction one output; all inputs after reset.
// - Driver enable is product term OR direction.
// - Array output overrides data out writes.
`timescale 1ns/1ns
`default_nettype none
module mfio_port_mux #(
  parameter int PORT_W = mfio_pkg::PORT_W
) (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Static pin-function configuration.
  input  wire logic [7:0]                cfg_mcell_a,
  input  wire logic [7:0]                cfg_mcell_b,
  input  wire logic [7:0]                cfg_sel_c,
  input  wire logic                      cfg_bus16,
  input  wire logic                      cfg_isp_dedicated,
  input  wire logic                      cfg_d_clk,
  input  wire logic                      cfg_d_csel,
  input  wire logic                      cfg_d_ubw,
  input  wire mfio_pkg::mfio_isc_mode_t  cfg_isc_mode [3],
  // Processor register access.
  input  wire logic [5:0]                reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  // Processor data bus path.
  input  wire logic                      bus_rd,
  input  wire logic [15:0]               bus_rdata,
  output logic      [15:0]               bus_wdata,
  // Logic array connections.
  input  wire logic [7:0]                first_macrocell_group,
  input  wire logic [7:0]                second_macrocell_group,
  input  wire logic [7:0]                decoded_external_select,
  input  wire logic [7:0]                oe_pt [3],
  input  wire logic [2:0]                isc_clk_pt,
  input  wire logic                      isp_array_pt,
  output logic      [7:0]                input_sampling_cell [3],
  output logic      [3:0]                pd_to_array,
  output logic                           array_clock_input,
  output logic                           upper_byte_write_strobe,
  output logic                           mem_standby,
  // In-system programming serial lines.
  input  wire logic                      isp_tdo,
  output logic                           isp_tms,
  output logic                           isp_tck,
  output logic                           isp_tdi,
  // Port pins, order A, B, C, D, E, G; port D uses bits 3-0.
  input  wire logic [7:0]                port_i [6],
  output logic      [7:0]                port_o [6],
  output logic      [7:0]                port_oe [6],
  output logic      [7:0]                pf_o,
  output logic                           pf_oe,
  input  wire logic [7:0]                pf_i,
  output logic      [7:0]                fast_slew_c
);
  localparam int NP = mfio_pkg::NPORT;

  if (PORT_W != 8) begin : g_chk
    $error("Port width must be 8.");
  end

  logic [7:0] dout [NP];
  logic [7:0] dir [NP];
  logic [7:0] drv [NP];
  logic [7:0] next_dout [NP];
  logic [7:0] next_dir [NP];
  logic [7:0] next_drv [NP];
  logic       isp_reg;
  logic       next_isp_reg;
  logic [7:0] next_rdata;
  logic       standby_now;
  logic       isp_on;
  logic [2:0] pt_d;
  logic [7:0] next_isc [3];
  logic [7:0] alt_en [NP];
  logic [7:0] alt_bit [NP];
  logic [7:0] alt_oe [NP];
  logic [7:0] od [NP];
  logic [7:0] fin [NP];
  logic [7:0] dir_eff [NP];
  logic [7:0] pmask;

  assign standby_now = cfg_d_csel & port_i[3][mfio_pkg::PD_CSI_BIT];
  assign isp_on      = cfg_isp_dedicated | isp_array_pt | isp_reg;

  // Register file; deselect freezes only this block, never the pin paths.
  always_comb begin
    next_isp_reg = isp_reg;
    next_rdata   = mfio_pkg::REG_RESET;
    pmask        = (reg_addr[5:3] == mfio_pkg::PORT_D) ? mfio_pkg::PORT_D_MASK
                                                       : mfio_pkg::FULL_MASK;
    for (int p = 0; p < NP; p++) begin
      next_dout[p] = dout[p];
      next_dir[p]  = dir[p];
      next_drv[p]  = drv[p];
    end
    if (!standby_now && reg_addr[5:3] == mfio_pkg::PORT_MISC) begin
      if (reg_wr && reg_addr[2:0] == mfio_pkg::REG_ISP_CTRL) begin
        next_isp_reg = reg_wdata[mfio_pkg::ISP_EN_BIT];
      end
      if (reg_rd && reg_addr[2:0] == mfio_pkg::REG_ISP_CTRL) begin
        next_rdata[mfio_pkg::ISP_EN_BIT] = isp_reg;
      end
    end else if (!standby_now && reg_addr[5:3] < 3'(NP)) begin
      if (reg_wr) begin
        case (reg_addr[2:0])
          mfio_pkg::REG_DATA_OUT:  next_dout[reg_addr[5:3]] = reg_wdata & pmask;
          mfio_pkg::REG_DIRECTION: next_dir[reg_addr[5:3]]  = reg_wdata & pmask;
          mfio_pkg::REG_DRIVE:     next_drv[reg_addr[5:3]]  = reg_wdata & pmask;
          default:                 next_isp_reg = isp_reg;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr[2:0])
          mfio_pkg::REG_DATA_IN:    next_rdata = port_i[reg_addr[5:3]] & pmask;
          mfio_pkg::REG_DATA_OUT:   next_rdata = dout[reg_addr[5:3]];
          mfio_pkg::REG_DIRECTION:  next_rdata = dir[reg_addr[5:3]];
          mfio_pkg::REG_DRIVE:      next_rdata = drv[reg_addr[5:3]];
          mfio_pkg::REG_ENABLE_OUT: next_rdata = port_oe[reg_addr[5:3]] & pmask;
          default:                  next_rdata = mfio_pkg::REG_RESET;
        endcase
      end
    end
  end

  // Source selection per pin, fixed by configuration except port E, where the programming term or register also selects.
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      alt_en[p]  = 8'h00;
      alt_bit[p] = 8'h00;
      alt_oe[p]  = 8'h00;
      od[p]      = 8'h00;
      fin[p]     = 8'h00;
      dir_eff[p] = dir[p];
    end
    alt_en[0]  = cfg_mcell_a;
    alt_bit[0] = first_macrocell_group;
    alt_oe[0]  = cfg_mcell_a & oe_pt[0];
    od[0]      = drv[0];
    alt_en[1]  = cfg_mcell_b;
    alt_bit[1] = second_macrocell_group;
    alt_oe[1]  = cfg_mcell_b & oe_pt[1];
    od[1]      = drv[1];
    alt_en[2]  = cfg_sel_c;
    alt_bit[2] = decoded_external_select;
    alt_oe[2]  = cfg_sel_c & oe_pt[2];
    fin[3]     = {4'h0, cfg_d_ubw, cfg_d_csel, cfg_d_clk, 1'b0};
    od[4]      = drv[4];
    if (isp_on) begin
      fin[4][2:0]                   = 3'b111;
      alt_en[4][mfio_pkg::ISP_TDO_BIT]  = 1'b1;
      alt_bit[4][mfio_pkg::ISP_TDO_BIT] = isp_tdo;
      alt_oe[4][mfio_pkg::ISP_TDO_BIT]  = 1'b1;
      od[4][3:0]                    = 4'h0;
    end
    if (cfg_bus16) begin
      alt_en[5]  = 8'hff;
      alt_bit[5] = bus_rdata[15:8];
      alt_oe[5]  = {8{bus_rd}};
      dir_eff[5] = 8'h00;
    end else begin
      od[5] = drv[5];
    end
  end

  // Input cells of ports A to C: pass, latch on a high term, or capture on its rising edge.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      case (cfg_isc_mode[p])
        mfio_pkg::ISC_PASS:  next_isc[p] = port_i[p];
        mfio_pkg::ISC_LATCH: next_isc[p] = isc_clk_pt[p] ? port_i[p] : input_sampling_cell[p];
        mfio_pkg::ISC_REG:   next_isc[p] = (isc_clk_pt[p] & ~pt_d[p]) ? port_i[p]
                                                                      : input_sampling_cell[p];
        default:             next_isc[p] = input_sampling_cell[p];
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NP; p++) begin
        dout[p] <= mfio_pkg::REG_RESET;
        dir[p]  <= mfio_pkg::REG_RESET;
        drv[p]  <= mfio_pkg::REG_RESET;
      end
      for (int p = 0; p < 3; p++) begin
        input_sampling_cell[p] <= 8'h00;
      end
      isp_reg                 <= 1'b0;
      reg_rdata               <= mfio_pkg::REG_RESET;
      pt_d                    <= 3'h0;
      pf_o                    <= 8'h00;
      pf_oe                   <= 1'b0;
      bus_wdata               <= 16'h0000;
      pd_to_array             <= 4'h0;
      array_clock_input       <= 1'b0;
      upper_byte_write_strobe <= 1'b0;
      mem_standby             <= 1'b0;
      isp_tms                 <= 1'b0;
      isp_tck                 <= 1'b0;
      isp_tdi                 <= 1'b0;
      fast_slew_c             <= 8'h00;
    end else begin
      for (int p = 0; p < NP; p++) begin
        dout[p] <= next_dout[p];
        dir[p]  <= next_dir[p];
        drv[p]  <= next_drv[p];
      end
      for (int p = 0; p < 3; p++) begin
        input_sampling_cell[p] <= next_isc[p];
      end
      isp_reg                 <= next_isp_reg;
      reg_rdata               <= next_rdata;
      pt_d                    <= isc_clk_pt;
      pf_o                    <= bus_rdata[7:0];
      pf_oe                   <= bus_rd;
      bus_wdata               <= {cfg_bus16 ? port_i[5] : 8'h00, pf_i};
      pd_to_array             <= port_i[3][3:0];
      array_clock_input       <= cfg_d_clk & port_i[3][mfio_pkg::PD_CLK_BIT];
      upper_byte_write_strobe <= cfg_d_ubw & port_i[3][mfio_pkg::PD_UBW_BIT];
      mem_standby             <= standby_now;
      isp_tms                 <= isp_on & port_i[4][mfio_pkg::ISP_TMS_BIT];
      isp_tck                 <= isp_on & port_i[4][mfio_pkg::ISP_TCK_BIT];
      isp_tdi                 <= isp_on & port_i[4][mfio_pkg::ISP_TDI_BIT];
      fast_slew_c             <= drv[2];
    end
  end

  // Port D has only four pins; its upper lanes stay undriven.
  for (genvar p = 0; p < NP; p++) begin : g_port
    for (genvar b = 0; b < 8; b++) begin : g_bit
      if (p != 3 || b < 4) begin : g_cell
        mfio_pin_cell u_cell (
          .clk        (clk),
          .rst_n      (rst_n),
          .dout_bit   (dout[p][b]),
          .dir        (dir_eff[p][b]),
          .open_drain (od[p][b]),
          .alt_en     (alt_en[p][b]),
          .alt_bit    (alt_bit[p][b]),
          .alt_oe     (alt_oe[p][b]),
          .force_in   (fin[p][b]),
          .pin_o      (port_o[p][b]),
          .pin_oe     (port_oe[p][b])
        );
      end else begin : g_none
        assign port_o[p][b]  = 1'b0;
        assign port_oe[p][b] = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  enable_status_a:
    assert property ((reg_rd && !standby_now && reg_addr == {mfio_pkg::PORT_A,
      mfio_pkg::REG_ENABLE_OUT}) |=> reg_rdata == $past(port_oe[0]))
    else $error("Enable status read disagrees with drivers.");
  port_f_bus_a:
    assert property (bus_rd |=> (pf_oe && pf_o == $past(bus_rdata[7:0])))
    else $error("Port F did not carry low data byte.");
  port_g_bus_a:
    assert property ((cfg_bus16 && !bus_rd) ##1 (cfg_bus16 && !bus_rd) |=> port_oe[5] == 8'h00)
    else $error("Port G driven outside a bus read.");
  isp_off_a:
    assert property (!isp_on |=> !(isp_tms || isp_tck || isp_tdi))
    else $error("Programming lines active while disabled.");
  mcell_drive_a:
    assert property (1'b1 |=> ((port_o[0] ^ $past(first_macrocell_group)) & $past(cfg_mcell_a)
      & ~$past(drv[0])) == 8'h00)
    else $error("Port A does not follow macrocell group.");
  select_drive_a:
    assert property ((cfg_sel_c == 8'hff) |=> port_o[2] == $past(decoded_external_select))
    else $error("Port C does not follow decoded selects.");
  pd_direct_a:
    assert property (1'b1 |=> pd_to_array == $past(port_i[3][3:0]))
    else $error("Port D array input mismatch.");
  clock_in_a:
    assert property (cfg_d_clk |=> array_clock_input == $past(port_i[3][1]))
    else $error("Array clock input mismatch.");
  standby_freeze_a:
    assert property ((standby_now && reg_wr) |=> ($stable(dir[0]) && mem_standby))
    else $error("Register changed while deselected.");
  config_select_a:
    assert property (cfg_bus16 |=> port_o[5] == $past(bus_rdata[15:8]))
    else $error("Port G source does not follow configuration.");
  cover_bus16_rd: cover property (cfg_bus16 && bus_rd);
  cover_isp_on: cover property (isp_on ##1 isp_tck);
  cover_standby: cover property (standby_now && reg_wr);
endmodule
`default_nettype wire

// ---- bench/mfio_board_model.sv ----
// Board-side model of the port pins: pull-ups, external drivers and the device drivers.
`timescale 1ns/1ns
`default_nettype none
module mfio_board_model (
  // Device pin drivers.
  input  wire logic [7:0] port_o  [6],
  input  wire logic [7:0] port_oe [6],
  // Board drivers in place of the external parties.
  input  wire logic [7:0] ext_val [6],
  input  wire logic [7:0] ext_en  [6],
  // Resolved pin levels.
  output logic      [7:0] port_i  [6]
);
  // Every pin carries a pull-up, so a released pin or an open-drain high reads one.
  // The board only drives a pin that the device leaves alone, so contention is not modelled.
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (port_oe[p][b]) begin
          port_i[p][b] = port_o[p][b];
        end else if (ext_en[p][b]) begin
          port_i[p][b] = ext_val[p][b];
        end else begin
          port_i[p][b] = 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/test_multi_function_io_port_mux.sv ----
// Self-checking testbench of the I/O port multiplexer.
`timescale 1ns/1ns
`default_nettype none
module test_multi_function_io_port_mux;
  localparam logic [2:0] PA = mfio_pkg::PORT_A, PB = mfio_pkg::PORT_B, PC = mfio_pkg::PORT_C;
  localparam logic [2:0] PD = mfio_pkg::PORT_D, PE = mfio_pkg::PORT_E, PG = mfio_pkg::PORT_G;
  localparam logic [2:0] DIN = mfio_pkg::REG_DATA_IN, DOUT = mfio_pkg::REG_DATA_OUT;
  localparam logic [2:0] DIR = mfio_pkg::REG_DIRECTION, DRV = mfio_pkg::REG_DRIVE;
  localparam logic [2:0] ENO = mfio_pkg::REG_ENABLE_OUT;
  logic                     clk = 1'b0, rst_n = 1'b0;
  logic [7:0]               cfg_mcell_a, cfg_mcell_b, cfg_sel_c;
  logic                     cfg_bus16, cfg_isp_dedicated, cfg_d_clk, cfg_d_csel, cfg_d_ubw;
  mfio_pkg::mfio_isc_mode_t cfg_isc_mode [3];
  logic [5:0]               reg_addr;
  logic                     reg_wr, reg_rd, bus_rd, isp_array_pt, isp_tdo;
  logic [7:0]               reg_wdata, reg_rdata, mca, mcb, dsel, pf_o, pf_i, fast_slew_c, v;
  logic [15:0]              bus_rdata, bus_wdata;
  logic [7:0]               oe_pt [3], isc [3];
  logic [2:0]               isc_clk_pt;
  logic [3:0]               pd_to_array;
  logic                     aclk, ubw, stby, isp_tms, isp_tck, isp_tdi, pf_oe;
  logic [7:0]               port_i [6], port_o [6], port_oe [6], ext_val [6], ext_en [6];
  int                       n_mismatch = 0, total_checks = 0, cyc = 0;

  mfio_port_mux u_mfio_port_mux (
    .clk(clk), .rst_n(rst_n), .cfg_mcell_a(cfg_mcell_a), .cfg_mcell_b(cfg_mcell_b),
    .cfg_sel_c(cfg_sel_c), .cfg_bus16(cfg_bus16), .cfg_isp_dedicated(cfg_isp_dedicated),
    .cfg_d_clk(cfg_d_clk), .cfg_d_csel(cfg_d_csel), .cfg_d_ubw(cfg_d_ubw),
    .cfg_isc_mode(cfg_isc_mode), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .bus_wdata(bus_wdata), .first_macrocell_group(mca), .second_macrocell_group(mcb),
    .decoded_external_select(dsel), .oe_pt(oe_pt), .isc_clk_pt(isc_clk_pt),
    .isp_array_pt(isp_array_pt), .input_sampling_cell(isc), .pd_to_array(pd_to_array),
    .array_clock_input(aclk), .upper_byte_write_strobe(ubw), .mem_standby(stby),
    .isp_tdo(isp_tdo), .isp_tms(isp_tms), .isp_tck(isp_tck), .isp_tdi(isp_tdi),
    .port_i(port_i), .port_o(port_o), .port_oe(port_oe), .pf_o(pf_o), .pf_oe(pf_oe),
    .pf_i(pf_i), .fast_slew_c(fast_slew_c));
  mfio_board_model u_mfio_board_model (
    .port_o(port_o), .port_oe(port_oe), .ext_val(ext_val), .ext_en(ext_en), .port_i(port_i));

  always #10 clk = ~clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] p, input logic [2:0] r, input logic [7:0] d);
    @(negedge clk);
    reg_addr = {p, r};
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // The read data stands for one cycle only, so it is taken at the next falling edge.
  task automatic rd(input logic [2:0] p, input logic [2:0] r, output logic [7:0] d);
    @(negedge clk);
    reg_addr = {p, r};
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic t_reset();
    for (int i = 0; i < 6; i++) chk(port_oe[i], 8'h00, "oe after reset");
    rd(PA, ENO, v);
    chk(v, 8'h00, "enable status after reset");
    $display("done: reset");
  endtask

  task automatic t_gpio();
    mcb = 8'h0c;
    wr(PB, DIR, 8'hff);
    wr(PB, DOUT, 8'ha5);
    settle();
    chk(port_oe[1], 8'hff, "B oe");
    chk(port_o[1], 8'hac, "B array over data out");
    rd(PB, ENO, v);
    chk(v, 8'hff, "B status");
    wr(PB, DIR, 8'h00);
    oe_pt[1] = 8'h0f;
    settle();
    chk(port_oe[1], 8'h0f, "B term or direction");
    rd(PB, ENO, v);
    chk(v, 8'h0f, "B status term");
    $display("done: gpio");
  endtask

  task automatic t_portc_imc();
    dsel = 8'h96;
    oe_pt[2] = 8'hff;
    oe_pt[0] = 8'hf0;
    mca = 8'h50;
    ext_en[0] = 8'h0f;
    ext_val[0] = 8'h0c;
    wr(PC, DRV, 8'h3c);
    settle();
    chk(port_o[2], 8'h96, "C selects");
    chk(fast_slew_c, 8'h3c, "C slew");
    chk(port_o[0] & port_oe[0], 8'h50, "A cells");
    chk(isc[0], 8'h5c, "A pass cell");
    chk(isc[2], 8'h00, "C held");
    @(negedge clk);
    isc_clk_pt = 3'b110;
    settle();
    isc_clk_pt = 3'b000;
    chk(isc[2], 8'h96, "C captured");
    chk(isc[1], 8'hfc, "B latched");
    $display("done: port c and input cells");
  endtask

  task automatic t_portd();
    ext_en[3] = 8'h0f;
    ext_val[3] = 8'h0a;
    settle();
    chk(pd_to_array, 4'ha, "D direct");
    chk({aclk, ubw, stby}, 3'b110, "D functions");
    wr(PD, DIR, 8'hff);
    rd(PD, DIR, v);
    chk(v, 8'h0f, "D four pins");
    chk(port_oe[3], 8'h01, "D dedicated pins stay inputs");
    wr(PD, DIR, 8'h00);
    ext_val[3] = 8'h04;
    settle();
    chk(stby, 1'b1, "deselect");
    chk(pd_to_array, 4'h4, "array runs");
    wr(PE, DOUT, 8'h33);
    rd(PE, DOUT, v);
    chk(v, 8'h00, "read refused");
    ext_val[3] = 8'h00;
    settle();
    rd(PE, DOUT, v);
    chk({stby, v}, 9'h000, "write lost");
    $display("done: port d");
  endtask

  task automatic t_porte();
    wr(PE, DIR, 8'hff);
    wr(PE, DOUT, 8'h55);
    wr(PE, DRV, 8'hff);
    settle();
    chk(port_oe[4], 8'haa, "E open drain");
    rd(PE, DIN, v);
    chk(v, 8'h55, "E pins");
    wr(PE, DIR, 8'h00);
    $display("done: port e");
  endtask

  task automatic t_fg8();
    pf_i = 8'h5a;
    bus_rd = 1'b1;
    bus_rdata = 16'h7e81;
    wr(PG, DIR, 8'hff);
    wr(PG, DOUT, 8'h3c);
    settle();
    chk({pf_oe, pf_o}, 9'h181, "F read drive");
    chk(port_o[5] & port_oe[5], 8'h3c, "G io");
    chk(bus_wdata, 16'h005a, "F in, G zero");
    bus_rd = 1'b0;
    $display("done: ports f and g narrow");
  endtask

  task automatic t_isp();
    ext_en[4] = 8'h07;
    ext_val[4] = 8'h03;
    isp_tdo = 1'b1;
    isp_array_pt = 1'b1;
    settle();
    chk({isp_tms, isp_tck, isp_tdi}, 3'b110, "serial in");
    chk(port_o[4][3] & port_oe[4][3], 1'b1, "serial out");
    isp_array_pt = 1'b0;
    settle();
    chk(isp_tck, 1'b0, "serial off");
    wr(mfio_pkg::PORT_MISC, mfio_pkg::REG_ISP_CTRL, 8'h01);
    settle();
    chk(isp_tck, 1'b1, "serial by register");
    wr(mfio_pkg::PORT_MISC, mfio_pkg::REG_ISP_CTRL, 8'h00);
    rd(3'h6, 3'h0, v);
    chk(v, 8'h00, "unmapped");
    $display("done: programming port");
  endtask

  task automatic t_bus16();
    @(negedge clk);
    rst_n = 1'b0;
    cfg_bus16 = 1'b1;
    settle();
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) chk(port_oe[i], 8'h00, "oe after reset");
    wr(PG, DIR, 8'hff);
    ext_en[5] = 8'hff;
    ext_val[5] = 8'he7;
    settle();
    chk(port_oe[5], 8'h00, "G not io");
    chk(bus_wdata, 16'he75a, "G high byte");
    ext_en[5] = 8'h00;
    bus_rd = 1'b1;
    bus_rdata = 16'hc3a5;
    settle();
    chk(port_o[5], 8'hc3, "G drives data");
    chk(port_oe[5], 8'hff, "G data oe");
    bus_rd = 1'b0;
    $display("done: wide bus");
  endtask

  initial begin
    {cfg_mcell_a, cfg_mcell_b, cfg_sel_c} = {8'hf0, 8'h0f, 8'hff};
    {cfg_bus16, cfg_isp_dedicated} = 2'b00;
    {cfg_d_clk, cfg_d_csel, cfg_d_ubw} = 3'b111;
    cfg_isc_mode = '{mfio_pkg::ISC_PASS, mfio_pkg::ISC_LATCH, mfio_pkg::ISC_REG};
    {reg_addr, reg_wr, reg_rd, reg_wdata, bus_rd, bus_rdata} = '0;
    {mca, mcb, dsel, isc_clk_pt, isp_array_pt, isp_tdo, pf_i} = '0;
    oe_pt = '{8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) {ext_val[i], ext_en[i]} = 16'h0000;
    // The pull-up would deselect the registers, so the board holds chip select low.
    ext_en[3] = 8'h04;
    settle();
    rst_n = 1'b1;
    t_reset();
    t_gpio();
    t_portc_imc();
    t_portd();
    t_porte();
    t_fg8();
    t_isp();
    t_bus16();
    wrap_up();
  end
endmodule
`default_nettype wire
